// *** include/shra_pkg.sv ***
package shra_pkg;

   // Slave address range: 16 steps of one from the base (address byte 0x90 to 0xAE)
   localparam logic [6:0] SHRA_ADDR_BASE = 7'h48;
   localparam logic [6:0] SHRA_ADDR_LAST = 7'h57;

   // Strap classification codes, in address order
   localparam logic [1:0] SHRA_STRAP_VDD = 2'h0;
   localparam logic [1:0] SHRA_STRAP_VSS = 2'h1;
   localparam logic [1:0] SHRA_STRAP_SCL = 2'h2;
   localparam logic [1:0] SHRA_STRAP_SDA = 2'h3;

   // Register address byte layout
   localparam int SHRA_REG_LSB    = 3;
   localparam int SHRA_CH_LSB     = 1;
   localparam int SHRA_SPI_RW_BIT = 7;

   // Direction bit values
   localparam logic SHRA_DIR_READ = 1'h1;

   // Bit counting
   localparam logic [3:0] SHRA_BYTE_BITS = 4'h8;
   localparam logic [3:0] SHRA_LAST_BIT  = 4'h7;

   // Register access request towards the UART register file
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] ch;
      logic [3:0] sel;
      logic [7:0] data;
   } shra_req_t;

   function automatic logic [3:0] shra_reg_field(input logic [7:0] b);
      return b[SHRA_REG_LSB +: 4];
   endfunction

   function automatic logic [1:0] shra_ch_field(input logic [7:0] b);
      return b[SHRA_CH_LSB +: 2];
   endfunction

endpackage

// *** rtl/shra_strap_decode.sv ***
`timescale 1ns/1ps
module shra_strap_decode (
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   // Strap and bus lines
   input  wire logic       strap_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // Classification
   output logic [1:0]      code_out
);
   import shra_pkg::*;

   logic seen_low;
   logic seen_high;
   logic diff_scl;
   logic diff_sda;

   // A strap tied to a bus line is told apart by bus activity; the START
   // condition already separates SCL from SDA before the first address bit.
   wire [1:0] next_code = !seen_low  ? SHRA_STRAP_VDD :
                          !seen_high ? SHRA_STRAP_VSS :
                          !diff_scl  ? SHRA_STRAP_SCL : SHRA_STRAP_SDA;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         seen_low  <= 1'b0;
         seen_high <= 1'b0;
         diff_scl  <= 1'b0;
         diff_sda  <= 1'b0;
         code_out  <= SHRA_STRAP_VDD;
      end else begin
         seen_low  <= seen_low | ~strap_in;
         seen_high <= seen_high | strap_in;
         diff_scl  <= diff_scl | (strap_in ^ scl_in);
         diff_sda  <= diff_sda | (strap_in ^ sda_in);
         code_out  <= next_code;
      end
   end

endmodule

// *** rtl/shra_top.sv ***
// Functional notes
// - Slave address comes from two four-level straps, sixteen evenly spaced addresses.
// - Both straps high gives address byte 0x90, the lowest one.
// - Address byte bit 0 is direction: 0 write, 1 read.
// - Sub-address is a full 8-bit byte without direction, and is acknowledged.
// - Each written data byte goes in turn to the sub-addressed register.
// - Device shifts out bytes from the sub-address; master acks all but last.
// - SPI register byte: bit 7 direction (1 read), 6:3 register, 2:1 channel.
// - Device pulls data low in the acknowledge clock of its own address byte and of every byte received after it.
`timescale 1ns/1ps
module shra_top (
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   // Interface select: high for I2C, low for SPI
   input  wire logic              i2c_mode_in,
   // Address straps
   input  wire logic              addr_strap_high_in,
   input  wire logic              addr_strap_low_in,
   // I2C lines
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe_out,
   // SPI lines
   input  wire logic              spi_cs_n_in,
   input  wire logic              spi_sck_in,
   input  wire logic              spi_mosi_in,
   output logic                   spi_miso_out,
   // Register file side
   output shra_pkg::shra_req_t    req_out,
   input  wire logic [7:0]        rd_data_in
);
   import shra_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ADDR     = 4'h1,
      ST_ADDR_ACK = 4'h3,
      ST_SUB      = 4'h2,
      ST_SUB_ACK  = 4'h6,
      ST_WDATA    = 4'h7,
      ST_WACK     = 4'h5,
      ST_RDATA    = 4'h4,
      ST_RACK     = 4'hC,
      ST_IGNORE   = 4'hD
   } shra_state_t;

   shra_state_t state;
   shra_state_t next_state;
   logic        scl_q;
   logic        sda_q;
   logic        sck_q;
   logic [7:0]  rx;
   logic [7:0]  tx;
   logic [3:0]  cnt;
   logic        rw;
   logic        spi_first;
   logic [1:0]  code_hi;
   logic [1:0]  code_lo;

   shra_strap_decode u_strap_hi (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .strap_in (addr_strap_high_in),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .code_out (code_hi)
   );

   shra_strap_decode u_strap_lo (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .strap_in (addr_strap_low_in),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .code_out (code_lo)
   );

   wire [6:0] own_addr    = SHRA_ADDR_BASE + {3'h0, code_hi, code_lo};
   wire       scl_rise    = scl_in & ~scl_q;
   wire       scl_fall    = ~scl_in & scl_q;
   wire       start_cond  = scl_in & scl_q & sda_q & ~sda_in;
   wire       stop_cond   = scl_in & scl_q & ~sda_q & sda_in;
   wire       i2c_live    = i2c_mode_in & ~start_cond & ~stop_cond;
   wire       sck_rise    = spi_sck_in & ~sck_q;
   wire       sck_fall    = ~spi_sck_in & sck_q;
   wire [7:0] rx_next     = {rx[6:0], sda_in};
   wire [7:0] mosi_next   = {rx[6:0], spi_mosi_in};
   wire       byte_done   = (cnt == SHRA_BYTE_BITS);
   wire       last_bit    = (cnt == SHRA_LAST_BIT);
   wire       addr_match  = (rx[7:1] == own_addr);
   wire       rx_state    = (state == ST_ADDR) || (state == ST_SUB) || (state == ST_WDATA);
   wire       byte_end    = scl_fall & byte_done;
   wire       fetch_first = (state == ST_ADDR_ACK) & (rw == SHRA_DIR_READ);
   wire       fetch_more  = (state == ST_RACK) & ~sda_in;
   wire       spi_live    = ~i2c_mode_in & ~spi_cs_n_in;
   wire       spi_cmd     = spi_live & sck_rise & spi_first & last_bit;

   always_comb begin
      next_state = state;
      if (!i2c_mode_in) begin
         next_state = ST_IDLE;
      end else if (start_cond) begin
         next_state = ST_ADDR;
      end else if (stop_cond) begin
         next_state = ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE, ST_IGNORE: next_state = state;
            ST_ADDR: begin
               if (byte_end) begin
                  next_state = addr_match ? ST_ADDR_ACK : ST_IGNORE;
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  next_state = (rw == SHRA_DIR_READ) ? ST_RDATA : ST_SUB;
               end
            end
            ST_SUB: begin
               if (byte_end) begin
                  next_state = ST_SUB_ACK;
               end
            end
            ST_SUB_ACK, ST_WACK: begin
               if (scl_fall) begin
                  next_state = ST_WDATA;
               end
            end
            ST_WDATA: begin
               if (byte_end) begin
                  next_state = ST_WACK;
               end
            end
            ST_RDATA: begin
               if (scl_fall && last_bit) begin
                  next_state = ST_RACK;
               end
            end
            ST_RACK: begin
               // Negative acknowledge ends the read; wait for STOP or START
               if (scl_rise && sda_in) begin
                  next_state = ST_IGNORE;
               end else if (scl_fall) begin
                  next_state = ST_RDATA;
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         scl_q        <= 1'h1;
         sda_q        <= 1'h1;
         sck_q        <= 1'h0;
         state        <= ST_IDLE;
         rx           <= 8'h00;
         tx           <= 8'h00;
         cnt          <= 4'h0;
         rw           <= 1'h0;
         spi_first    <= 1'h1;
         sda_out      <= 1'h0;
         sda_oe_out   <= 1'h0;
         spi_miso_out <= 1'h0;
         req_out      <= '0;
      end else begin
         scl_q      <= scl_in;
         sda_q      <= sda_in;
         sck_q      <= spi_sck_in;
         state      <= next_state;
         req_out.wr <= 1'h0;
         req_out.rd <= 1'h0;
         if (req_out.rd) begin
            tx <= rd_data_in;
         end
         if (!i2c_mode_in) begin
            sda_oe_out <= 1'h0;
            if (spi_cs_n_in) begin
               cnt          <= 4'h0;
               spi_first    <= 1'h1;
               spi_miso_out <= 1'h0;
            end else begin
               if (sck_rise) begin
                  rx  <= mosi_next;
                  cnt <= last_bit ? 4'h0 : cnt + 4'h1;
               end
               if (spi_cmd) begin
                  spi_first   <= 1'h0;
                  rw          <= mosi_next[SHRA_SPI_RW_BIT];
                  req_out.rd  <= mosi_next[SHRA_SPI_RW_BIT] == SHRA_DIR_READ;
                  req_out.sel <= shra_reg_field(mosi_next);
                  req_out.ch  <= shra_ch_field(mosi_next);
               end else if (sck_rise && last_bit && rw == SHRA_DIR_READ) begin
                  // Prefetch for the next byte; one extra read at frame end
                  req_out.rd <= 1'h1;
               end else if (sck_rise && last_bit) begin
                  req_out.wr   <= 1'h1;
                  req_out.data <= mosi_next;
               end
               if (sck_fall && !spi_first && rw == SHRA_DIR_READ) begin
                  spi_miso_out <= tx[7];
                  tx           <= {tx[6:0], 1'h0};
               end
            end
         end else if (start_cond || stop_cond) begin
            cnt        <= 4'h0;
            sda_oe_out <= 1'h0;
         end else begin
            if (scl_rise && rx_state) begin
               rx  <= rx_next;
               cnt <= cnt + 4'h1;
            end
            if (scl_rise && (fetch_first || fetch_more)) begin
               req_out.rd <= 1'h1;
            end
            if (scl_fall) begin
               unique case (state)
                  ST_ADDR: begin
                     if (byte_done) begin
                        rw         <= rx[0];
                        sda_oe_out <= addr_match;
                        cnt        <= 4'h0;
                     end
                  end
                  ST_SUB: begin
                     if (byte_done) begin
                        req_out.sel <= shra_reg_field(rx);
                        req_out.ch  <= shra_ch_field(rx);
                        sda_oe_out  <= 1'h1;
                        cnt         <= 4'h0;
                     end
                  end
                  ST_WDATA: begin
                     if (byte_done) begin
                        req_out.wr   <= 1'h1;
                        req_out.data <= rx;
                        sda_oe_out   <= 1'h1;
                        cnt          <= 4'h0;
                     end
                  end
                  ST_ADDR_ACK, ST_RACK: begin
                     cnt        <= 4'h0;
                     sda_oe_out <= (rw == SHRA_DIR_READ) & ~tx[7];
                     tx         <= {tx[6:0], 1'h0};
                  end
                  ST_RDATA: begin
                     cnt        <= cnt + 4'h1;
                     sda_oe_out <= ~last_bit & ~tx[7];
                     tx         <= {tx[6:0], 1'h0};
                  end
                  ST_SUB_ACK, ST_WACK: begin
                     sda_oe_out <= 1'h0;
                     cnt        <= 4'h0;
                  end
                  default: cnt <= cnt;
               endcase
            end
         end
      end
   end

   chk_addr_window: assert property (@(posedge clock_in) disable iff (rst_in)
      own_addr >= SHRA_ADDR_BASE && own_addr <= SHRA_ADDR_LAST)
      else $error("slave address outside strap range");

   chk_vdd_address: assert property (@(posedge clock_in) disable iff (rst_in)
      (code_hi == SHRA_STRAP_VDD && code_lo == SHRA_STRAP_VDD) |-> own_addr == SHRA_ADDR_BASE)
      else $error("both straps high must give the lowest address");

   chk_addr_ack: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c_live && state == ST_ADDR && byte_end && addr_match)
      |=> sda_oe_out && state == ST_ADDR_ACK)
      else $error("matching address not acknowledged");

   chk_addr_nack: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c_live && state == ST_ADDR && byte_end && !addr_match)
      |=> !sda_oe_out && state == ST_IGNORE)
      else $error("foreign address was acknowledged");

   chk_read_dir: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c_live && scl_rise && fetch_first) |=> req_out.rd ##1 !req_out.rd)
      else $error("read address did not fetch one byte");

   chk_sub_decode: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c_live && state == ST_SUB && byte_end)
      |=> sda_oe_out && req_out.sel == shra_reg_field($past(rx))
          && req_out.ch == shra_ch_field($past(rx)))
      else $error("sub-address not acknowledged or decoded");

   chk_write_store: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c_live && state == ST_WDATA && byte_end)
      |=> req_out.wr && req_out.data == $past(rx) ##1 !req_out.wr)
      else $error("data byte not stored once");

   chk_read_next: assert property (@(posedge clock_in) disable iff (rst_in)
      (i2c_live && state == ST_RACK && scl_rise && !sda_in) |=> req_out.rd)
      else $error("acknowledged read did not fetch next byte");

   chk_spi_dir: assert property (@(posedge clock_in) disable iff (rst_in)
      spi_cmd |=> req_out.rd == $past(mosi_next[SHRA_SPI_RW_BIT]) && !req_out.wr)
      else $error("SPI direction bit misread");

endmodule

// *** verif/shra_master_model.sv ***
`timescale 1ns/1ps
module shra_master_model (
   // Clock
   input  wire logic clock_in,
   // Device outputs
   input  wire logic sda_oe_in,
   input  wire logic miso_in,
   // Bus lines
   output logic      scl_out,
   output logic      sda_out,
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      mosi_out
);
   localparam int HALF = 4;
   logic pull_low;
   // Pull-up wire: low when either side pulls
   assign sda_out = ~(pull_low | sda_oe_in);
   initial begin
      scl_out = 1'b1;
      pull_low = 1'b0;
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      mosi_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   // Also serves as repeated start
   task automatic start_cond();
      pull_low = 1'b0;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      pull_low = 1'b1;
      tick(HALF);
      scl_out = 1'b0;
   endtask
   task automatic stop_cond();
      pull_low = 1'b1;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      pull_low = 1'b0;
      tick(HALF);
   endtask
   // Wire sampled at the end of SCL high, after the device has settled
   task automatic bit_io(input logic b, output logic s);
      pull_low = ~b;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      s = sda_out;
      scl_out = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic ack_it, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~ack_it, s);
   endtask
   // Deselected data line toggles so a stale level is never mistaken for data
   task automatic spi_frame_edge(input logic cs_n);
      cs_n_out = cs_n;
      if (cs_n) mosi_out = ~mosi_out;
      tick(HALF);
   endtask
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         tick(3);
         sck_out = 1'b1;
         rx[i] = miso_in;
         tick(3);
         sck_out = 1'b0;
      end
   endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import shra_pkg::*;
   logic        clock_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        i2c_mode_in;
   logic [1:0]  strap_hi;
   logic [1:0]  strap_lo;
   logic        scl, sda, sda_drv, sda_oe, cs_n, sck, mosi, miso;
   logic        addr_strap_high_in, addr_strap_low_in;
   shra_req_t   req_out;
   logic [7:0]  rd_data_in;
   logic [3:0]  rd_cnt = 4'h0;
   logic [15:0] wr_q[$];
   int          n_mismatch = 0;
   int          compares = 0;

   always #20 clock_in = ~clock_in;

   // Tie order: supply high, supply low, clock line, data line
   function automatic logic tie(input logic [1:0] c, input logic s, input logic d);
      return c == 2'h0 ? 1'b1 : c == 2'h1 ? 1'b0 : c == 2'h2 ? s : d;
   endfunction
   assign addr_strap_high_in = tie(strap_hi, scl, sda);
   assign addr_strap_low_in  = tie(strap_lo, scl, sda);
   // Register stand-in: each read returns a fresh count beside the register number
   assign rd_data_in = {rd_cnt, req_out.sel};
   always @(posedge clock_in) begin
      if (req_out.wr === 1'b1) wr_q.push_back(req_out);
      if (req_out.rd === 1'b1) rd_cnt <= rd_cnt + 4'h1;
   end

   shra_top i_shra_top (
      .clock_in, .rst_in, .i2c_mode_in, .addr_strap_high_in, .addr_strap_low_in,
      .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
      .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_mosi_in(mosi), .spi_miso_out(miso),
      .req_out, .rd_data_in
   );
   shra_master_model mdl (
      .clock_in, .sda_oe_in(sda_oe), .miso_in(miso), .scl_out(scl), .sda_out(sda),
      .cs_n_out(cs_n), .sck_out(sck), .mosi_out(mosi)
   );

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reset_dut();
      rst_in = 1'b1;
      mdl.tick(5);
      rst_in = 1'b0;
      mdl.tick(1);
   endtask
   task automatic open_i2c(input logic [7:0] adr, input logic [7:0] sub);
      logic ack;
      mdl.start_cond();
      mdl.send_byte(adr, ack);
      check(16'(ack), 16'h1);
      mdl.send_byte(sub, ack);
      check(16'(ack), 16'h1);
   endtask
   task automatic test_straps();
      logic [7:0] own;
      logic       ack;
      for (int h = 0; h < 4; h++) begin
         for (int l = 0; l < 4; l++) begin
            strap_hi = 2'(h);
            strap_lo = 2'(l);
            own = 8'h90 + 8'(8 * h + 2 * l);
            reset_dut();
            open_i2c(own, 8'h00);
            mdl.start_cond();
            mdl.send_byte(own ^ 8'h02, ack);
            check(16'(ack), 16'h0);
            mdl.send_byte(8'h00, ack);
            check(16'(ack), 16'h0);
            mdl.stop_cond();
         end
      end
      $display("test straps done");
   endtask
   task automatic test_write();
      logic ack;
      strap_hi = 2'h0;
      strap_lo = 2'h0;
      reset_dut();
      wr_q.delete();
      open_i2c(8'h90, 8'hA9);
      mdl.send_byte(8'h3C, ack);
      check(16'(ack), 16'h1);
      mdl.send_byte(8'hC3, ack);
      check(16'(ack), 16'h1);
      mdl.stop_cond();
      // Open-drain: the driven level is always low, and the line is released after STOP
      check(16'(sda_drv), 16'h0);
      check(16'(sda_oe), 16'h0);
      check(16'(wr_q.size()), 16'h2);
      check(wr_q[0], {2'b10, 2'b00, 4'h5, 8'h3C});
      check(wr_q[1], {2'b10, 2'b00, 4'h5, 8'hC3});
      $display("test write done");
   endtask
   task automatic test_read();
      logic [3:0] base;
      logic [7:0] b;
      logic       ack;
      base = rd_cnt;
      open_i2c(8'h90, 8'h10);
      mdl.start_cond();
      mdl.send_byte(8'h91, ack);
      check(16'(ack), 16'h1);
      mdl.recv_byte(1'b1, b);
      check(16'(b), {8'h0, base, 4'h2});
      mdl.recv_byte(1'b0, b);
      check(16'(b), {8'h0, base + 4'h1, 4'h2});
      mdl.stop_cond();
      check(16'(rd_cnt - base), 16'h2);
      $display("test read done");
   endtask
   task automatic test_spi();
      logic [3:0] base;
      logic [7:0] rx;
      i2c_mode_in = 1'b0;
      reset_dut();
      wr_q.delete();
      mdl.spi_frame_edge(1'b0);
      mdl.spi_byte(8'h38, rx);
      mdl.spi_byte(8'h5A, rx);
      mdl.spi_frame_edge(1'b1);
      check(16'(wr_q.size()), 16'h1);
      check(wr_q[0], {2'b10, 2'b00, 4'h7, 8'h5A});
      base = rd_cnt;
      mdl.spi_frame_edge(1'b0);
      mdl.spi_byte(8'h98, rx);
      mdl.spi_byte(8'h00, rx);
      mdl.spi_frame_edge(1'b1);
      check(16'(rx), {8'h0, base, 4'h3});
      check(16'(wr_q.size()), 16'h1);
      i2c_mode_in = 1'b1;
      $display("test spi done");
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      i2c_mode_in = 1'b1;
      strap_hi    = 2'h0;
      strap_lo    = 2'h0;
      reset_dut();
      test_straps();
      test_write();
      test_read();
      test_spi();
      tally_and_finish();
   end
   // About 6200 clocks of traffic expected; allow well over three times that
   initial begin
      #1000000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
